// file: rtl/thi_pkg.sv
// Constants, register map and carrier types of the threshold event interrupt block.
// Behaviour
// - Pressure upper bound is 16 bits built from separate high and low byte registers.
// - With altitude select low, pressure thresholds compare as unsigned 0.02 mbar steps.
// - With altitude select high, thresholds compare as signed whole-meter altitudes.
// - Pressure middle threshold is 16 bits in two bytes, same format as upper.
// - Pressure lower bound is 16 bits in two bytes, format chosen by altitude select.
// - Temperature upper threshold is a signed 8-bit whole-degree value.
// - Temperature middle and lower thresholds are signed 8-bit whole-degree values.
// - Threshold error bit reads one when thresholds are badly ordered.
// - Six interrupt sources: two ready, two crossing, two out-of-window.
// - A ready flag sets when that channel's measurement completes.
// - A crossing flag sets when the new value crossed the middle threshold.
// - A window flag sets when the new value lies outside lower to upper.
// - All six flags are active high and stay set until cleared.
// - Result-reading or conversion commands clear the interrupt flags.
// - Each interrupt has its own enable bit, one enables it; crossing and window also need their channel's ready enable.
// - Per-interrupt output bit decides whether the flag reaches the pin.
// - Altitude select makes all pressure thresholds and flags refer to altitude.
// - Read-only status register holds six flags plus a device idle bit and the threshold error bit.
// - Device idle reads one only while no conversion or command runs.
// - Enabled flag with output bit zero shows in status without the pin.
package thi_pkg;

	// Register byte addresses.
	localparam logic [7:0] ADDR_PU_LOW  = 8'h02;
	localparam logic [7:0] ADDR_PU_HIGH = 8'h03;
	localparam logic [7:0] ADDR_PM_LOW  = 8'h04;
	localparam logic [7:0] ADDR_PM_HIGH = 8'h05;
	localparam logic [7:0] ADDR_PL_LOW  = 8'h06;
	localparam logic [7:0] ADDR_PL_HIGH = 8'h07;
	localparam logic [7:0] ADDR_TU      = 8'h08;
	localparam logic [7:0] ADDR_TM      = 8'h09;
	localparam logic [7:0] ADDR_TL      = 8'h0A;
	localparam logic [7:0] ADDR_EN      = 8'h0B;
	localparam logic [7:0] ADDR_CFG     = 8'h0C;
	localparam logic [7:0] ADDR_STATUS  = 8'h0D;

	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] BYTE_UNMAPPED = 8'h00;

	// Bit positions shared by the enable, config and status registers.
	localparam int BIT_THERR   = 7;
	localparam int BIT_IDLE    = 6;
	localparam int BIT_ALT_SEL = 6;
	localparam int BIT_PDONE   = 5;
	localparam int BIT_TDONE   = 4;
	localparam int BIT_PCROSS  = 3;
	localparam int BIT_TCROSS  = 2;
	localparam int BIT_POUT    = 1;
	localparam int BIT_TOUT    = 0;
	localparam int FLAG_W      = 6;
	localparam int CFG_W       = 7;

	localparam logic [FLAG_W-1:0] PRESS_FLAGS = 6'h2A;
	localparam logic [FLAG_W-1:0] TEMP_FLAGS  = 6'h15;
	localparam logic [FLAG_W-1:0] ALL_FLAGS   = 6'h3F;
	localparam logic [FLAG_W-1:0] NO_FLAGS    = 6'h00;

	// One register access carried across the clock domains.
	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} thi_req_t;

	// All threshold values as the comparators see them.
	typedef struct packed {
		logic [15:0] press_upper;
		logic [15:0] press_mid;
		logic [15:0] press_lower;
		logic [7:0]  temp_upper;
		logic [7:0]  temp_mid;
		logic [7:0]  temp_lower;
	} thi_thresh_t;

	// Link access state, Gray coded along idle, wait, done.
	typedef enum logic [1:0] {
		LK_IDLE = 2'b00,
		LK_WAIT = 2'b01,
		LK_DONE = 2'b11
	} thi_link_state_t;

endpackage

// file: rtl/thi_top.sv
// Threshold comparators, interrupt flags, pin routing and register access port.
`timescale 1ns/10ps
module thi_top
	import thi_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       link_clk,
	input  wire logic       link_rst,
	input  wire logic       link_req,
	input  wire logic       link_we,
	input  wire logic [7:0] link_addr,
	input  wire logic [7:0] link_wdata,
	output logic            link_busy,
	output logic            link_done,
	output logic [7:0]      link_rdata,
	input  wire logic       press_valid,
	input  wire logic [15:0] press_value,
	input  wire logic       temp_valid,
	input  wire logic [7:0] temp_value,
	input  wire logic       engine_busy,
	input  wire logic       clr_all,
	input  wire logic       clr_press,
	input  wire logic       clr_temp,
	input  wire logic       soft_rst,
	output logic            alt_select,
	output logic            irq_pin
);

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.

	thi_link_state_t   link_state_reg;
	thi_req_t          req_data_reg;
	logic              req_tgl_reg;
	logic              ack_s1_reg;
	logic              ack_s2_reg;
	logic              ack_s3_reg;
	logic              ack_seen_reg;
	logic              ack_evt;
	logic              link_busy_reg;
	logic              link_done_reg;
	logic [7:0]        link_rdata_reg;

	logic              req_s1_reg;
	logic              req_s2_reg;
	logic              req_s3_reg;
	logic              req_seen_reg;
	logic              req_evt;
	logic              ack_tgl_reg;
	logic [7:0]        resp_data_reg;

	thi_thresh_t       thr_reg;
	logic [FLAG_W-1:0] en_reg;
	logic [CFG_W-1:0]  cfg_reg;
	logic [FLAG_W-1:0] flags_reg;
	logic [FLAG_W-1:0] flags_next;
	logic [FLAG_W-1:0] flag_set;
	logic [FLAG_W-1:0] flag_clr;
	logic              therr_reg;
	logic              therr_next;
	logic              idle_reg;
	logic              irq_pin_reg;

	logic              p_above;
	logic              p_below;
	logic              p_out;
	logic              p_side;
	logic              p_cross;
	logic              p_side_reg;
	logic              p_hist_reg;
	logic              t_out;
	logic              t_side;
	logic              t_cross;
	logic              t_side_reg;
	logic              t_hist_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Helper functions.

	// Sixteen-bit less-than, signed in altitude mode and unsigned in pressure mode.
	function automatic logic less16(input logic [15:0] a, input logic [15:0] b,
		input logic sgn);
		if (sgn) begin
			less16 = $signed(a) < $signed(b);
		end else begin
			less16 = a < b;
		end
	endfunction

	// Register read multiplexer; unmapped addresses read as zero.
	function automatic logic [7:0] rd_mux(input logic [7:0] addr, input thi_thresh_t t,
		input logic [FLAG_W-1:0] en, input logic [CFG_W-1:0] cfg,
		input logic [FLAG_W-1:0] flg, input logic err, input logic idle);
		case (addr)
			ADDR_PU_LOW:  rd_mux = t.press_upper[7:0];
			ADDR_PU_HIGH: rd_mux = t.press_upper[15:8];
			ADDR_PM_LOW:  rd_mux = t.press_mid[7:0];
			ADDR_PM_HIGH: rd_mux = t.press_mid[15:8];
			ADDR_PL_LOW:  rd_mux = t.press_lower[7:0];
			ADDR_PL_HIGH: rd_mux = t.press_lower[15:8];
			ADDR_TU:      rd_mux = t.temp_upper;
			ADDR_TM:      rd_mux = t.temp_mid;
			ADDR_TL:      rd_mux = t.temp_lower;
			ADDR_EN:      rd_mux = 8'(en);
			ADDR_CFG:     rd_mux = 8'(cfg);
			ADDR_STATUS:  rd_mux = {err, idle, flg};
			default:      rd_mux = BYTE_UNMAPPED;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: access sequencer.

	// The request word is held steady until the core acknowledges, so the core may
	// sample it as a whole once the toggle arrives.
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			link_state_reg <= LK_IDLE;
			req_data_reg   <= '0;
			req_tgl_reg    <= 1'b0;
			link_busy_reg  <= 1'b0;
			link_done_reg  <= 1'b0;
			link_rdata_reg <= BYTE_RESET;
		end else begin
			case (link_state_reg)
				LK_IDLE: begin
					link_done_reg <= 1'b0;
					if (link_req) begin
						req_data_reg   <= '{we: link_we, addr: link_addr, wdata: link_wdata};
						req_tgl_reg    <= ~req_tgl_reg;
						link_busy_reg  <= 1'b1;
						link_state_reg <= LK_WAIT;
					end
				end
				LK_WAIT: begin
					if (ack_evt) begin
						link_rdata_reg <= resp_data_reg;
						link_busy_reg  <= 1'b0;
						link_done_reg  <= 1'b1;
						link_state_reg <= LK_DONE;
					end
				end
				LK_DONE: begin
					link_done_reg  <= 1'b0;
					link_state_reg <= LK_IDLE;
				end
				default: begin
					link_done_reg  <= 1'b0;
					link_busy_reg  <= 1'b0;
					link_state_reg <= LK_IDLE;
				end
			endcase
		end
	end

	// Acknowledge toggle synchroniser; a change counts once stages two and three agree.
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			ack_s1_reg   <= 1'b0;
			ack_s2_reg   <= 1'b0;
			ack_s3_reg   <= 1'b0;
			ack_seen_reg <= 1'b0;
		end else begin
			ack_s1_reg <= ack_tgl_reg;
			ack_s2_reg <= ack_s1_reg;
			ack_s3_reg <= ack_s2_reg;
			if (ack_evt) begin
				ack_seen_reg <= ack_s3_reg;
			end
		end
	end

	assign ack_evt = (ack_s2_reg == ack_s3_reg) && (ack_s3_reg != ack_seen_reg);

	assign link_busy  = link_busy_reg;
	assign link_done  = link_done_reg;
	assign link_rdata = link_rdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Core domain: request crossing and register file.

	// Request toggle synchroniser, same agreement scheme as the acknowledge path.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			req_s1_reg   <= 1'b0;
			req_s2_reg   <= 1'b0;
			req_s3_reg   <= 1'b0;
			req_seen_reg <= 1'b0;
		end else begin
			req_s1_reg <= req_tgl_reg;
			req_s2_reg <= req_s1_reg;
			req_s3_reg <= req_s2_reg;
			if (req_evt) begin
				req_seen_reg <= req_s3_reg;
			end
		end
	end

	assign req_evt = (req_s2_reg == req_s3_reg) && (req_s3_reg != req_seen_reg);

	// Read data is captured in the same cycle the acknowledge toggles, so it is stable at the link.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ack_tgl_reg   <= 1'b0;
			resp_data_reg <= BYTE_RESET;
		end else if (req_evt) begin
			ack_tgl_reg   <= ~ack_tgl_reg;
			resp_data_reg <= rd_mux(req_data_reg.addr, thr_reg, en_reg, cfg_reg,
				flags_reg, therr_reg, idle_reg);
		end
	end

	// Threshold, enable and config writes; status and unmapped writes are dropped.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			thr_reg <= '0;
			en_reg  <= NO_FLAGS;
			cfg_reg <= '0;
		end else if (req_evt && req_data_reg.we) begin
			case (req_data_reg.addr)
				ADDR_PU_LOW:  thr_reg.press_upper[7:0]  <= req_data_reg.wdata;
				ADDR_PU_HIGH: thr_reg.press_upper[15:8] <= req_data_reg.wdata;
				ADDR_PM_LOW:  thr_reg.press_mid[7:0]    <= req_data_reg.wdata;
				ADDR_PM_HIGH: thr_reg.press_mid[15:8]   <= req_data_reg.wdata;
				ADDR_PL_LOW:  thr_reg.press_lower[7:0]  <= req_data_reg.wdata;
				ADDR_PL_HIGH: thr_reg.press_lower[15:8] <= req_data_reg.wdata;
				ADDR_TU:      thr_reg.temp_upper <= req_data_reg.wdata;
				ADDR_TM:      thr_reg.temp_mid   <= req_data_reg.wdata;
				ADDR_TL:      thr_reg.temp_lower <= req_data_reg.wdata;
				ADDR_EN:      en_reg  <= req_data_reg.wdata[FLAG_W-1:0];
				ADDR_CFG:     cfg_reg <= req_data_reg.wdata[CFG_W-1:0];
				default:      thr_reg <= thr_reg;
			endcase
		end
	end

	assign alt_select = cfg_reg[BIT_ALT_SEL];

	////////////////////////////////////////////////////////////////////////////////
	// Comparators.

	// Pressure or altitude against its window and middle; format follows altitude select.
	always_comb begin
		p_above = less16(thr_reg.press_upper, press_value, cfg_reg[BIT_ALT_SEL]);
		p_below = less16(press_value, thr_reg.press_lower, cfg_reg[BIT_ALT_SEL]);
		p_out   = p_above | p_below;
		p_side  = ~less16(press_value, thr_reg.press_mid, cfg_reg[BIT_ALT_SEL]);
		p_cross = p_hist_reg && (p_side != p_side_reg);
	end

	// Temperature is always signed whole degrees.
	always_comb begin
		t_out   = ($signed(temp_value) > $signed(thr_reg.temp_upper)) ||
		          ($signed(temp_value) < $signed(thr_reg.temp_lower));
		t_side  = $signed(temp_value) >= $signed(thr_reg.temp_mid);
		t_cross = t_hist_reg && (t_side != t_side_reg);
	end

	// Side of the middle threshold of the last result; the first result after reset
	// has no history and cannot count as a crossing.
	always_ff @(posedge clock) begin
		if (sys_rst || soft_rst) begin
			p_side_reg <= 1'b0;
			p_hist_reg <= 1'b0;
			t_side_reg <= 1'b0;
			t_hist_reg <= 1'b0;
		end else begin
			if (press_valid) begin
				p_side_reg <= p_side;
				p_hist_reg <= 1'b1;
			end
			if (temp_valid) begin
				t_side_reg <= t_side;
				t_hist_reg <= 1'b1;
			end
		end
	end

	// Ordering check covers lower above upper and a middle outside the window.
	always_comb begin
		therr_next =
			less16(thr_reg.press_upper, thr_reg.press_lower, cfg_reg[BIT_ALT_SEL]) ||
			less16(thr_reg.press_mid, thr_reg.press_lower, cfg_reg[BIT_ALT_SEL]) ||
			less16(thr_reg.press_upper, thr_reg.press_mid, cfg_reg[BIT_ALT_SEL]) ||
			($signed(thr_reg.temp_upper) < $signed(thr_reg.temp_lower)) ||
			($signed(thr_reg.temp_mid) < $signed(thr_reg.temp_lower)) ||
			($signed(thr_reg.temp_upper) < $signed(thr_reg.temp_mid));
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flags and pin.

	// Crossing and window only set with their channel's ready enabled, so the ready
	// flag is always present when they are; clearing ready therefore clears them too.
	always_comb begin
		flag_set = NO_FLAGS;
		flag_set[BIT_PDONE]  = press_valid && en_reg[BIT_PDONE];
		flag_set[BIT_TDONE]  = temp_valid && en_reg[BIT_TDONE];
		flag_set[BIT_PCROSS] = press_valid && p_cross && en_reg[BIT_PCROSS] &&
		                       en_reg[BIT_PDONE];
		flag_set[BIT_TCROSS] = temp_valid && t_cross && en_reg[BIT_TCROSS] &&
		                       en_reg[BIT_TDONE];
		flag_set[BIT_POUT]   = press_valid && p_out && en_reg[BIT_POUT] &&
		                       en_reg[BIT_PDONE];
		flag_set[BIT_TOUT]   = temp_valid && t_out && en_reg[BIT_TOUT] &&
		                       en_reg[BIT_TDONE];
		if (clr_all || soft_rst) begin
			flag_clr = ALL_FLAGS;
		end else begin
			flag_clr = (clr_press ? PRESS_FLAGS : NO_FLAGS) |
			           (clr_temp ? TEMP_FLAGS : NO_FLAGS);
		end
		flags_next = (flags_reg & ~flag_clr) | flag_set;
	end

	// Six sticky flags; a new result in the clearing cycle wins.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			flags_reg <= NO_FLAGS;
		end else begin
			flags_reg <= flags_next;
		end
	end

	// Status bits; idle is a registered inverse of the engine's busy level.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			therr_reg <= 1'b0;
			idle_reg  <= 1'b0;
		end else begin
			therr_reg <= therr_next;
			idle_reg  <= ~engine_busy;
		end
	end

	// Pin follows enabled and routed flags, one cycle behind the status register.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_pin_reg <= 1'b0;
		end else begin
			irq_pin_reg <= |(flags_reg & en_reg & cfg_reg[FLAG_W-1:0]);
		end
	end

	assign irq_pin = irq_pin_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	chk_ready_set: assert property (@(posedge clock) disable iff (sys_rst)
		press_valid && en_reg[BIT_PDONE] |=> flags_reg[BIT_PDONE])
		else $error("pressure ready flag not set after enabled result");

	chk_cross_cause: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(flags_reg[BIT_PCROSS]) |-> $past(press_valid) && $past(p_hist_reg))
		else $error("pressure crossing flag set without a new result");

	chk_window_set: assert property (@(posedge clock) disable iff (sys_rst)
		temp_valid && t_out && en_reg[BIT_TOUT] && en_reg[BIT_TDONE]
		|=> flags_reg[BIT_TOUT])
		else $error("temperature window flag missing for value outside window");

	chk_flag_sticky: assert property (@(posedge clock) disable iff (sys_rst)
		!(clr_all || clr_press || clr_temp || soft_rst)
		|=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
		else $error("flag dropped without a clearing command");

	chk_clear_all: assert property (@(posedge clock) disable iff (sys_rst)
		clr_all && !press_valid && !temp_valid |=> flags_reg == NO_FLAGS)
		else $error("flags remain after a clearing command");

	chk_enable_gate: assert property (@(posedge clock) disable iff (sys_rst)
		!en_reg[BIT_TDONE] && !flags_reg[BIT_TDONE] |=> !flags_reg[BIT_TDONE])
		else $error("disabled temperature ready flag was set");

	chk_pin_route: assert property (@(posedge clock) disable iff (sys_rst)
		##1 irq_pin_reg == $past(|(flags_reg & en_reg & cfg_reg[FLAG_W-1:0])))
		else $error("interrupt pin does not match routed flags");

	chk_quiet_flag: assert property (@(posedge clock) disable iff (sys_rst)
		cfg_reg[FLAG_W-1:0] == NO_FLAGS ##1 cfg_reg[FLAG_W-1:0] == NO_FLAGS
		|-> !irq_pin_reg ##1 !irq_pin_reg)
		else $error("interrupt pin raised with no routed interrupt");

	chk_idle_track: assert property (@(posedge clock) disable iff (sys_rst)
		engine_busy |=> !idle_reg)
		else $error("idle bit set while engine busy");

	chk_order_error: assert property (@(posedge clock) disable iff (sys_rst)
		$signed(thr_reg.temp_lower) > $signed(thr_reg.temp_upper) |=> therr_reg)
		else $error("threshold error bit missing for reversed temperature window");

endmodule

// file: verif/thi_host.sv
// Host-side model that issues single register accesses on the link port.
`timescale 1ns/10ps
module thi_host (
	input  wire logic       link_clk,
	input  wire logic       link_done,
	input  wire logic [7:0] link_rdata,
	output logic            link_req,
	output logic            link_we,
	output logic [7:0]      link_addr,
	output logic [7:0]      link_wdata
);

	////////////////////////////////////////////////////////////////////////////////
	// The idle address starts at a value that no access uses, so a stale address never looks valid.
	initial begin
		link_req = 1'b0;
		link_we = 1'b0;
		link_addr = 8'hFF;
		link_wdata = 8'hFF;
	end

	// One access: a request pulse, then a bounded wait for done with everything held.
	// A lost answer comes back unknown, so the caller's compare counts it.
	task automatic access(input logic we, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] rd);
		int n;
		n = 0;
		@(posedge link_clk);
		link_req <= 1'b1;
		link_we <= we;
		link_addr <= a;
		link_wdata <= d;
		@(posedge link_clk);
		link_req <= 1'b0;
		#1;
		while (link_done !== 1'b1 && n < 40) begin
			@(posedge link_clk);
			#1;
			n++;
		end
		rd = (n < 40) ? link_rdata : 8'hXX;
		// Released lines show the inverse, since the simulator would settle them anyhow.
		link_we <= ~we;
		link_addr <= ~a;
		link_wdata <= ~d;
	endtask

endmodule

// file: verif/testbench.sv
// Self-checking bench comparing flags, pin and registers with a behavioural model.
`timescale 1ns/10ps
module testbench;
	import thi_pkg::*;

	logic        clock = 1'b0;
	logic        link_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        link_rst = 1'b1;
	logic        press_valid = 1'b0;
	logic        temp_valid = 1'b0;
	logic        engine_busy = 1'b0;
	logic        clr_all = 1'b0;
	logic        clr_press = 1'b0;
	logic        clr_temp = 1'b0;
	logic        soft_rst = 1'b0;
	logic [15:0] press_value = 16'h0000;
	logic [7:0]  temp_value = 8'h00;
	logic        link_req, link_we, link_busy, link_done, alt_select, irq_pin;
	logic [7:0]  link_addr, link_wdata, link_rdata, rd;
	int          fails = 0;
	int          num_checks = 0;
	int          seed = 85284;
	int          cycles = 0;
	int          busy_hi = 0;
	int          k, v;
	int          regs [16];
	int          flags = 0;
	int          prev [2] = '{-1, -1};

	////////////////////////////////////////////////////////////////////////////////
	// Core clock at 50 ns; link clock at 64 ns with its own phase.
	always #25 clock = ~clock;
	initial begin
		#7;
		forever #32 link_clk = ~link_clk;
	end

	thi_top i_thi_top (.clock, .sys_rst, .link_clk, .link_rst, .link_req, .link_we, .link_addr,
		.link_wdata, .link_busy, .link_done, .link_rdata, .press_valid, .press_value,
		.temp_valid, .temp_value, .engine_busy, .clr_all, .clr_press, .clr_temp, .soft_rst,
		.alt_select, .irq_pin);

	thi_host u_host (.link_clk, .link_done, .link_rdata, .link_req, .link_we, .link_addr,
		.link_wdata);

	////////////////////////////////////////////////////////////////////////////////
	// Model: sign handling, thresholds (k 0 upper, 1 mid, 2 lower) and expected bytes.
	function automatic int sx(int x, int w, bit sgn);
		return (sgn && x >= (1 << (w - 1))) ? x - (1 << w) : x;
	endfunction

	function automatic int th(int c, int k);
		return c ? sx(regs[3 + 2 * k] * 256 + regs[2 + 2 * k], 16, regs[12][6])
			: sx(regs[8 + k], 8, 1'b1);
	endfunction

	function automatic int rdexp(int a);
		int err;
		err = 0;
		for (int c = 0; c < 2; c++)
			if (th(c, 2) > th(c, 0) || th(c, 1) < th(c, 2) || th(c, 1) > th(c, 0)) err = 1;
		if (a == 13) return err * 128 + (engine_busy ? 0 : 64) + flags;
		return (a >= 2 && a <= 12) ? regs[a] : 0;
	endfunction

	task automatic cmp_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmp_pin(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask

	// A write returns the byte held before it; reserved bits are dropped by the model.
	task automatic wr(input int a, input int d);
		u_host.access(1'b1, a[7:0], d[7:0], rd);
		cmp_reg("prior byte", rdexp(a), rd);
		if (a >= 2 && a <= 12) regs[a] = d & (a == 11 ? 63 : a == 12 ? 127 : 255);
	endtask

	task automatic rdchk(input int a);
		u_host.access(1'b0, a[7:0], 8'h5A, rd);
		cmp_reg("read byte", rdexp(a), rd);
		cmp_pin("link_busy", 1'b0, link_busy);
		cmp_pin("link_busy seen", 1'b1, busy_hi != 0);
		busy_hi = 0;
	endtask

	// Feed one result; the pin follows two core cycles after the valid pulse.
	task automatic meas(input int c, input int val);
		int x, s;
		x = c ? sx(val & 65535, 16, regs[12][6]) : sx(val & 255, 8, 1'b1);
		s = x >= th(c, 1);
		if (regs[11][4 + c]) begin
			flags |= 1 << (4 + c);
			if (regs[11][2 + c] && prev[c] >= 0 && prev[c] != s) flags |= 1 << (2 + c);
			if (regs[11][c] && (x > th(c, 0) || x < th(c, 2))) flags |= 1 << c;
		end
		prev[c] = s;
		@(posedge clock);
		press_valid <= c[0];
		temp_valid <= ~c[0];
		press_value <= val[15:0];
		temp_value <= val[7:0];
		@(posedge clock);
		press_valid <= 1'b0;
		temp_valid <= 1'b0;
		press_value <= ~val[15:0];
		temp_value <= ~val[7:0];
		repeat (2) @(posedge clock);
		#1;
		cmp_pin("irq_pin", (flags & regs[11] & regs[12] & 63) != 0, irq_pin);
	endtask

	// Clear pulses: 0 all, 1 pressure, 2 temperature, 3 soft reset with history.
	task automatic clr(input int k);
		@(posedge clock);
		clr_all <= (k == 0);
		clr_press <= (k == 1);
		clr_temp <= (k == 2);
		soft_rst <= (k == 3);
		@(posedge clock);
		{clr_all, clr_press, clr_temp, soft_rst} <= 4'h0;
		flags &= (k == 1) ? 21 : (k == 2) ? 42 : 0;
		if (k == 3) prev = '{-1, -1};
		repeat (2) @(posedge clock);
		#1;
		cmp_pin("irq_pin", (flags & regs[11] & regs[12] & 63) != 0, irq_pin);
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Count link edges that see the port busy, so a busy flag stuck low is caught.
	always @(posedge link_clk) begin
		if (link_busy === 1'b1) busy_hi++;
	end

	// The whole run should need about seven thousand core cycles; hang guard well above.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			give_verdict;
		end
	end

	// Main sequence: reset values, busy status, full writes, then random traffic.
	initial begin
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge link_clk);
		link_rst <= 1'b0;
		for (int a = 0; a < 16; a++) rdchk(a);
		rdchk(8'h80);
		@(posedge clock);
		engine_busy <= 1'b1;
		rdchk(13);
		@(posedge clock);
		engine_busy <= 1'b0;
		for (int a = 2; a < 14; a++) wr(a, 8'hFF);
		for (int a = 2; a < 14; a++) rdchk(a);
		wr(11, 8'h3F);
		wr(12, 8'h3F);
		repeat (300) begin
			k = $random(seed) & 7;
			v = $random(seed);
			case (k)
				0, 1: wr(2 + (v & 255) % 9, v >> 8);
				2: wr(11, (v & 63) | ((v & 10) ? 32 : 0) | ((v & 5) ? 16 : 0));
				3: begin
					wr(12, v);
					cmp_pin("alt_select", regs[12][6], alt_select);
				end
				4: meas(1, th(1, (v & 255) % 3) + (v >>> 24));
				5: meas(0, th(0, (v & 255) % 3) + (v >>> 28));
				6: clr(v & 3);
				default: begin
					rdchk((v & 255) % 20);
					wr(13, v);
				end
			endcase
			rdchk(13);
		end
		give_verdict;
	end

endmodule
